/* File: dms_pkg.sv */
// Constants and types for the data memory sector addressing block
package dms_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int unsigned DMS_DATA_W     = 8;
	localparam int unsigned DMS_EXT_ADDR_W = 10;
	localparam int unsigned DMS_SECTOR_W   = 2;
	localparam int unsigned DMS_SECTORS    = 3;
	localparam int unsigned DMS_GPR_BYTES  = 128;
	localparam int unsigned DMS_RAM_DEPTH  = DMS_SECTORS * DMS_GPR_BYTES;
	localparam int unsigned DMS_RAM_AW     = 9;
	localparam int unsigned DMS_SFR_AW     = 7;
	localparam int unsigned DMS_BIT_W      = 3;

	localparam logic [1:0] DMS_SECTOR_0   = 2'h0;
	localparam logic [1:0] DMS_SECTOR_1   = 2'h1;
	localparam logic [1:0] DMS_SECTOR_MAX = 2'h2;
	localparam logic [7:0] DMS_SECTOR_BYTE_MAX = 8'h02;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] DMS_OFF_INDIRECT_WINDOW_0     = 8'h00;
	localparam logic [7:0] DMS_OFF_POINTER_SECTOR0_ADDR  = 8'h01;
	localparam logic [7:0] DMS_OFF_INDIRECT_WINDOW_1     = 8'h02;
	localparam logic [7:0] DMS_OFF_POINTER1_LOCATION     = 8'h03;
	localparam logic [7:0] DMS_OFF_POINTER1_SECTOR_SEL   = 8'h04;
	localparam logic [7:0] DMS_OFF_WORKING_REGISTER      = 8'h05;
	localparam logic [7:0] DMS_OFF_INDIRECT_WINDOW_2     = 8'h0c;
	localparam logic [7:0] DMS_OFF_POINTER2_LOCATION     = 8'h0d;
	localparam logic [7:0] DMS_OFF_POINTER2_SECTOR_SEL   = 8'h0e;

	// Special-function area ends below this offset
	localparam logic [7:0] DMS_GPR_BASE = 8'h80;

	// Sector-1-only group: two offset ranges
	localparam logic [7:0] DMS_SEC1_A_LO = 8'h14;
	localparam logic [7:0] DMS_SEC1_A_HI = 8'h1b;
	localparam logic [7:0] DMS_SEC1_B_LO = 8'h2e;
	localparam logic [7:0] DMS_SEC1_B_HI = 8'h7f;

	// Unused and protected locations
	localparam logic [7:0] DMS_UNUSED_COMMON_A = 8'h47;
	localparam logic [7:0] DMS_UNUSED_COMMON_B = 8'h48;
	localparam logic [7:0] DMS_UNUSED_SEC1     = 8'h40;
	localparam logic [7:0] DMS_READONLY_SEC1   = 8'h7f;

	localparam logic [7:0] DMS_RESET_BYTE = 8'h00;
	localparam logic [7:0] DMS_NULL_BYTE  = 8'h00;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		DMS_OP_READ,
		DMS_OP_WRITE,
		DMS_OP_LOAD_ACC,
		DMS_OP_STORE_ACC,
		DMS_OP_BIT_SET,
		DMS_OP_BIT_CLR
	} dms_op_t;

	typedef enum logic [1:0] {
		DMS_TGT_GPR,
		DMS_TGT_SFR,
		DMS_TGT_NULL
	} dms_tgt_kind_t;

	typedef struct packed {
		logic                       valid;
		dms_op_t                    op;
		logic                       ext;
		logic [DMS_EXT_ADDR_W-1:0]  addr;
		logic [DMS_DATA_W-1:0]      wdata;
		logic [DMS_BIT_W-1:0]       bit_sel;
	} dms_req_t;

	typedef struct packed {
		logic                  valid;
		logic [DMS_DATA_W-1:0] rdata;
	} dms_rsp_t;

	typedef struct packed {
		dms_tgt_kind_t         kind;
		logic [1:0]            sector;
		logic [DMS_DATA_W-1:0] offset;
	} dms_target_t;

	typedef struct packed {
		logic [DMS_DATA_W-1:0] p0;
		logic [DMS_DATA_W-1:0] p1_loc;
		logic [DMS_DATA_W-1:0] p1_sec;
		logic [DMS_DATA_W-1:0] p2_loc;
		logic [DMS_DATA_W-1:0] p2_sec;
	} dms_pointers_t;

endpackage

/* File: dms_resolve.sv */
// Address resolution from instruction operand to sector and offset
`timescale 1ns/10ps
module dms_resolve
	import dms_pkg::*;
(
	input  wire dms_req_t      req_in,
	input  wire dms_pointers_t ptr_in,
	output dms_target_t        tgt_out
);

	logic [7:0] sector_byte;
	logic [7:0] offset;

	always_comb begin
		// Standard operands carry 8 bits and land in sector 0
		sector_byte = {6'h00, req_in.ext ? req_in.addr[9:8] : DMS_SECTOR_0};
		offset      = req_in.addr[7:0];
		if (req_in.addr[7:0] == DMS_OFF_INDIRECT_WINDOW_0) begin
			sector_byte = {6'h00, DMS_SECTOR_0};
			offset      = ptr_in.p0;
		end else if (req_in.addr[7:0] == DMS_OFF_INDIRECT_WINDOW_1) begin
			sector_byte = ptr_in.p1_sec;
			offset      = ptr_in.p1_loc;
		end else if (req_in.addr[7:0] == DMS_OFF_INDIRECT_WINDOW_2) begin
			sector_byte = ptr_in.p2_sec;
			offset      = ptr_in.p2_loc;
		end
		tgt_out.sector = sector_byte[1:0];
		tgt_out.offset = offset;
		if (sector_byte > DMS_SECTOR_BYTE_MAX) begin
			tgt_out.kind = DMS_TGT_NULL;
		end else if (offset == DMS_OFF_INDIRECT_WINDOW_0 ||
				offset == DMS_OFF_INDIRECT_WINDOW_1 ||
				offset == DMS_OFF_INDIRECT_WINDOW_2) begin
			tgt_out.kind = DMS_TGT_NULL;
		end else if (offset >= DMS_GPR_BASE) begin
			tgt_out.kind = DMS_TGT_GPR;
		end else begin
			tgt_out.kind = DMS_TGT_SFR;
		end
	end

endmodule

/* File: dms_gpr_ram.sv */
// General-purpose RAM of three 128-byte sectors with registered read
`timescale 1ns/10ps
module dms_gpr_ram
	import dms_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  we_in,
	input  wire logic [DMS_RAM_AW-1:0] waddr_in,
	input  wire logic [DMS_DATA_W-1:0] wdata_in,
	input  wire logic [DMS_RAM_AW-1:0] raddr_in,
	output logic      [DMS_DATA_W-1:0] rdata_out
);

	// ****************************************
	// Storage
	// ****************************************
	// No reset: behaves as plain RAM, contents undefined after power-up
	logic [DMS_DATA_W-1:0] mem [DMS_RAM_DEPTH];

	always_ff @(posedge clk_sys_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end

endmodule

/* File: dms_data_memory.sv */
// Data memory sector addressing: pointers, working register, SFR and RAM access
`timescale 1ns/10ps
module dms_data_memory
	import dms_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  nrst_in,
	input  wire dms_req_t              req_in,
	input  wire logic                  alu_valid_in,
	input  wire logic [DMS_DATA_W-1:0] alu_result_in,
	output logic                       ready_out,
	output dms_rsp_t                   rsp_out,
	output logic      [DMS_DATA_W-1:0] acc_out
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic {
		DMS_ST_IDLE,
		DMS_ST_EXEC
	} dms_state_t;

	dms_state_t            state_reg;
	dms_state_t            state_next;
	logic                  ready_reg;
	logic                  ready_next;
	dms_rsp_t              rsp_reg;
	dms_rsp_t              rsp_next;
	dms_target_t           tgt_reg;
	dms_target_t           tgt_next;
	dms_op_t               op_reg;
	dms_op_t               op_next;
	logic [DMS_DATA_W-1:0] wdata_reg;
	logic [DMS_DATA_W-1:0] wdata_next;
	logic [DMS_BIT_W-1:0]  bit_reg;
	logic [DMS_BIT_W-1:0]  bit_next;
	logic [DMS_DATA_W-1:0] acc_reg;
	logic [DMS_DATA_W-1:0] acc_next;
	dms_pointers_t         ptr_reg;
	dms_pointers_t         ptr_next;

	// Generic special-function storage: bank 0 common view, bank 1 sector-1-only view
	logic [DMS_DATA_W-1:0] sfr_reg  [2*DMS_GPR_BYTES];
	logic [DMS_DATA_W-1:0] sfr_next [2*DMS_GPR_BYTES];

	dms_target_t           tgt_now;
	logic                  accept;
	logic [DMS_DATA_W-1:0] ram_rdata;
	logic                  ram_we;
	logic [DMS_RAM_AW-1:0] ram_raddr;
	logic [DMS_RAM_AW-1:0] ram_waddr;
	logic [DMS_DATA_W-1:0] cur_val;
	logic [DMS_DATA_W-1:0] new_val;
	logic                  do_write;
	logic                  sec1_view;
	logic                  sfr_unused;
	logic                  sfr_readonly;
	logic [DMS_SFR_AW:0]   sfr_idx;
	logic [DMS_DATA_W-1:0] bit_mask;

	// ****************************************
	// Sub-blocks
	// ****************************************
	dms_resolve u_resolve (
		.req_in  (req_in),
		.ptr_in  (ptr_reg),
		.tgt_out (tgt_now)
	);

	dms_gpr_ram u_ram (
		.clk_sys_in (clk_sys_in),
		.we_in      (ram_we),
		.waddr_in   (ram_waddr),
		.wdata_in   (new_val),
		.raddr_in   (ram_raddr),
		.rdata_out  (ram_rdata)
	);

	// Sector number times 128 plus the low seven offset bits
	assign ram_raddr = {tgt_now.sector, tgt_now.offset[DMS_SFR_AW-1:0]};
	assign ram_waddr = {tgt_reg.sector, tgt_reg.offset[DMS_SFR_AW-1:0]};
	assign accept    = ready_reg && req_in.valid;

	// ****************************************
	// Special-function view decode
	// ****************************************
	always_comb begin
		sec1_view = (tgt_reg.sector == DMS_SECTOR_1) &&
			((tgt_reg.offset >= DMS_SEC1_A_LO && tgt_reg.offset <= DMS_SEC1_A_HI) ||
			 (tgt_reg.offset >= DMS_SEC1_B_LO && tgt_reg.offset <= DMS_SEC1_B_HI));
		sfr_idx = {sec1_view, tgt_reg.offset[DMS_SFR_AW-1:0]};
		if (tgt_reg.sector == DMS_SECTOR_1) begin
			sfr_unused = (tgt_reg.offset == DMS_UNUSED_SEC1);
		end else begin
			sfr_unused = (tgt_reg.offset == DMS_UNUSED_COMMON_A) ||
				(tgt_reg.offset == DMS_UNUSED_COMMON_B);
		end
		sfr_readonly = (tgt_reg.sector == DMS_SECTOR_1) &&
			(tgt_reg.offset == DMS_READONLY_SEC1);
	end

	// ****************************************
	// Current value of the resolved target
	// ****************************************
	always_comb begin
		cur_val = DMS_NULL_BYTE;
		unique case (tgt_reg.kind)
			DMS_TGT_GPR: begin
				cur_val = ram_rdata;
			end
			DMS_TGT_SFR: begin
				if (tgt_reg.offset == DMS_OFF_POINTER_SECTOR0_ADDR) begin
					cur_val = ptr_reg.p0;
				end else if (tgt_reg.offset == DMS_OFF_POINTER1_LOCATION) begin
					cur_val = ptr_reg.p1_loc;
				end else if (tgt_reg.offset == DMS_OFF_POINTER1_SECTOR_SEL) begin
					cur_val = ptr_reg.p1_sec;
				end else if (tgt_reg.offset == DMS_OFF_POINTER2_LOCATION) begin
					cur_val = ptr_reg.p2_loc;
				end else if (tgt_reg.offset == DMS_OFF_POINTER2_SECTOR_SEL) begin
					cur_val = ptr_reg.p2_sec;
				end else if (tgt_reg.offset == DMS_OFF_WORKING_REGISTER) begin
					cur_val = acc_reg;
				end else if (sfr_unused) begin
					cur_val = DMS_NULL_BYTE;
				end else begin
					cur_val = sfr_reg[sfr_idx];
				end
			end
			DMS_TGT_NULL: begin
				cur_val = DMS_NULL_BYTE;
			end
			default: begin
				cur_val = DMS_NULL_BYTE;
			end
		endcase
	end

	// ****************************************
	// New value and write qualification
	// ****************************************
	always_comb begin
		bit_mask = 8'h01 << bit_reg;
		new_val  = cur_val;
		do_write = 1'b0;
		unique case (op_reg)
			DMS_OP_READ: begin
				do_write = 1'b0;
			end
			DMS_OP_LOAD_ACC: begin
				do_write = 1'b0;
			end
			DMS_OP_WRITE: begin
				new_val  = wdata_reg;
				do_write = 1'b1;
			end
			DMS_OP_STORE_ACC: begin
				// The only path from one register to another runs through here
				new_val  = acc_reg;
				do_write = 1'b1;
			end
			DMS_OP_BIT_SET: begin
				new_val  = cur_val | bit_mask;
				do_write = 1'b1;
			end
			DMS_OP_BIT_CLR: begin
				new_val  = cur_val & ~bit_mask;
				do_write = 1'b1;
			end
			default: begin
				do_write = 1'b0;
			end
		endcase
		ram_we = (state_reg == DMS_ST_EXEC) && do_write && (tgt_reg.kind == DMS_TGT_GPR);
	end

	// ****************************************
	// Pointer, working register and SFR storage
	// ****************************************
	always_comb begin
		ptr_next = ptr_reg;
		acc_next = acc_reg;
		sfr_next = sfr_reg;
		if (alu_valid_in) begin
			acc_next = alu_result_in;
		end
		if (state_reg == DMS_ST_EXEC) begin
			if (op_reg == DMS_OP_LOAD_ACC) begin
				acc_next = cur_val;
			end
			if (do_write && tgt_reg.kind == DMS_TGT_SFR) begin
				// Each pointer byte is stored alone, so a low-byte step never carries
				if (tgt_reg.offset == DMS_OFF_POINTER_SECTOR0_ADDR) begin
					ptr_next.p0 = new_val;
				end else if (tgt_reg.offset == DMS_OFF_POINTER1_LOCATION) begin
					ptr_next.p1_loc = new_val;
				end else if (tgt_reg.offset == DMS_OFF_POINTER1_SECTOR_SEL) begin
					ptr_next.p1_sec = new_val;
				end else if (tgt_reg.offset == DMS_OFF_POINTER2_LOCATION) begin
					ptr_next.p2_loc = new_val;
				end else if (tgt_reg.offset == DMS_OFF_POINTER2_SECTOR_SEL) begin
					ptr_next.p2_sec = new_val;
				end else if (tgt_reg.offset == DMS_OFF_WORKING_REGISTER) begin
					acc_next = new_val;
				end else if (!sfr_unused && !sfr_readonly) begin
					sfr_next[sfr_idx] = new_val;
				end
			end
		end
	end

	// ****************************************
	// Request sequencing
	// ****************************************
	always_comb begin
		state_next = state_reg;
		ready_next = ready_reg;
		tgt_next   = tgt_reg;
		op_next    = op_reg;
		wdata_next = wdata_reg;
		bit_next   = bit_reg;
		rsp_next   = '{valid: 1'b0, rdata: rsp_reg.rdata};
		unique case (state_reg)
			DMS_ST_IDLE: begin
				if (accept) begin
					// RAM read starts now so its data meets the target in the next cycle
					tgt_next   = tgt_now;
					op_next    = req_in.op;
					wdata_next = req_in.wdata;
					bit_next   = req_in.bit_sel;
					ready_next = 1'b0;
					state_next = DMS_ST_EXEC;
				end
			end
			DMS_ST_EXEC: begin
				rsp_next   = '{valid: 1'b1, rdata: cur_val};
				ready_next = 1'b1;
				state_next = DMS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= DMS_ST_IDLE;
			ready_reg <= 1'b1;
			rsp_reg   <= '{valid: 1'b0, rdata: DMS_RESET_BYTE};
			tgt_reg   <= '{kind: DMS_TGT_NULL, sector: DMS_SECTOR_0, offset: DMS_RESET_BYTE};
			op_reg    <= DMS_OP_READ;
			wdata_reg <= DMS_RESET_BYTE;
			bit_reg   <= '0;
			acc_reg   <= DMS_RESET_BYTE;
			ptr_reg   <= '0;
		end else begin
			state_reg <= state_next;
			ready_reg <= ready_next;
			rsp_reg   <= rsp_next;
			tgt_reg   <= tgt_next;
			op_reg    <= op_next;
			wdata_reg <= wdata_next;
			bit_reg   <= bit_next;
			acc_reg   <= acc_next;
			ptr_reg   <= ptr_next;
		end
	end

	// ****************************************
	// Special-function storage
	// ****************************************
	// One register process per byte keeps the wide reset fan-out apart from the control flops
	for (genvar gi = 0; gi < 2*DMS_GPR_BYTES; gi++) begin : g_sfr
		always_ff @(posedge clk_sys_in or negedge nrst_in) begin
			if (!nrst_in) begin
				sfr_reg[gi] <= DMS_RESET_BYTE;
			end else begin
				sfr_reg[gi] <= sfr_next[gi];
			end
		end
	end

	assign ready_out = ready_reg;
	assign rsp_out   = rsp_reg;
	assign acc_out   = acc_reg;

endmodule

/* File: dms_data_memory_sva.sv */
// Assertion checker for the data memory sector addressing block
`timescale 1ns/10ps
module dms_data_memory_sva
	import dms_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  nrst_in,
	input  wire dms_req_t              req_in,
	input  wire logic                  alu_valid_in,
	input  wire logic [DMS_DATA_W-1:0] alu_result_in,
	input  wire logic                  ready_out,
	input  wire dms_rsp_t              rsp_out,
	input  wire logic [DMS_DATA_W-1:0] acc_out
);
	// ****************************************
	// Helpers
	// ****************************************
	logic taken;
	logic rd_taken;
	assign taken    = ready_out && req_in.valid;
	assign rd_taken = taken && (req_in.op == DMS_OP_READ);

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	// ****************************************
	// Properties
	// ****************************************
	AST_BUSY_GAP: assert property (taken |=> !ready_out ##1 ready_out)
		else $error("ready did not drop for exactly one cycle after a request");
	AST_RSP_TIME: assert property (taken |-> ##2 rsp_out.valid)
		else $error("response missing two cycles after a request");
	AST_RSP_CAUSE: assert property (rsp_out.valid |-> $past(taken, 2))
		else $error("response without a request two cycles before");
	AST_UNUSED_ZERO: assert property (rd_taken && !req_in.ext
		&& (req_in.addr[7:0] == DMS_UNUSED_COMMON_A || req_in.addr[7:0] == DMS_UNUSED_COMMON_B)
		|-> ##2 rsp_out.rdata == DMS_NULL_BYTE)
		else $error("unused location read nonzero");
	// Window offsets are redirected through a pointer, so they never reach sector 3 directly
	AST_SECTOR_NULL: assert property (rd_taken && req_in.ext && req_in.addr[9:8] == 2'h3
		&& req_in.addr[7:0] != DMS_OFF_INDIRECT_WINDOW_0
		&& req_in.addr[7:0] != DMS_OFF_INDIRECT_WINDOW_1
		&& req_in.addr[7:0] != DMS_OFF_INDIRECT_WINDOW_2
		|-> ##2 rsp_out.rdata == DMS_NULL_BYTE)
		else $error("sector above two read nonzero");
	AST_ALU_TO_ACC: assert property (alu_valid_in && ready_out
		|=> acc_out == $past(alu_result_in))
		else $error("ALU result not deposited in accumulator");
	AST_ACC_HOLD: assert property (ready_out && !alu_valid_in |=> $stable(acc_out))
		else $error("accumulator changed without a cause");
	AST_LOAD_ACC: assert property (taken && req_in.op == DMS_OP_LOAD_ACC
		|-> ##2 acc_out == rsp_out.rdata)
		else $error("load into accumulator gave a different value");
endmodule

bind dms_data_memory dms_data_memory_sva u_sva (
	.clk_sys_in    (clk_sys_in),
	.nrst_in       (nrst_in),
	.req_in        (req_in),
	.alu_valid_in  (alu_valid_in),
	.alu_result_in (alu_result_in),
	.ready_out     (ready_out),
	.rsp_out       (rsp_out),
	.acc_out       (acc_out)
);

/* File: dms_core_model.sv */
// Behavioural model of the requesting processor core and its ALU
`timescale 1ns/10ps
module dms_core_model
	import dms_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  ready_in,
	input  wire dms_rsp_t              rsp_in,
	output dms_req_t                   req_out,
	output logic                       alu_valid_out,
	output logic      [DMS_DATA_W-1:0] alu_result_out
);
	initial begin
		req_out = '0;
		alu_valid_out = 1'b0;
		alu_result_out = 8'h00;
	end

	// One access; rdata stays unknown if no response arrives in time
	task automatic xfer(input dms_op_t op, input logic ext, input logic [9:0] addr,
		input logic [7:0] wdata, input logic [2:0] bsel, output logic [7:0] rdata);
		int n;
		n = 0;
		rdata = 8'hxx;
		@(negedge clk_sys_in);
		while (ready_in !== 1'b1 && n < 16) begin
			@(negedge clk_sys_in);
			n++;
		end
		req_out <= '{valid: 1'b1, op: op, ext: ext, addr: addr, wdata: wdata, bit_sel: bsel};
		@(negedge clk_sys_in);
		// Released fields must not look like a held request
		req_out <= '{valid: 1'b0, op: op, ext: ext, addr: ~addr, wdata: ~wdata, bit_sel: bsel};
		n = 0;
		while (n < 4) begin
			@(negedge clk_sys_in);
			if (rsp_in.valid === 1'b1) begin
				rdata = rsp_in.rdata;
				n = 4;
			end
			n++;
		end
	endtask

	// ALU result handed to the accumulator for one edge
	task automatic alu(input logic [7:0] v);
		@(negedge clk_sys_in);
		alu_valid_out <= 1'b1;
		alu_result_out <= v;
		@(negedge clk_sys_in);
		alu_valid_out <= 1'b0;
		alu_result_out <= ~v;
	endtask
endmodule

/* File: test_data_memory_sector_addressing.sv */
// Self-checking testbench for the data memory sector addressing block
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_data_memory_sector_addressing;
	import dms_pkg::*;
	logic       clk_sys_in;
	logic       nrst_in;
	dms_req_t   req;
	logic       alu_valid;
	logic [7:0] alu_result;
	logic       ready;
	dms_rsp_t   rsp;
	logic [7:0] acc;
	logic [7:0] q;
	logic [7:0] ro;
	int         num_errors;
	int         samples_checked;
	logic [7:0] ptr_offs [6] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0d, 8'h0e};

	initial clk_sys_in = 1'b0;
	always #12.5 clk_sys_in = ~clk_sys_in;

	dms_data_memory u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req),
		.alu_valid_in(alu_valid), .alu_result_in(alu_result), .ready_out(ready),
		.rsp_out(rsp), .acc_out(acc));
	dms_core_model u_core (.clk_sys_in(clk_sys_in), .ready_in(ready), .rsp_in(rsp),
		.req_out(req), .alu_valid_out(alu_valid), .alu_result_out(alu_result));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic wr(input logic e, input logic [9:0] a, input logic [7:0] d);
		u_core.xfer(DMS_OP_WRITE, e, a, d, 3'h0, q);
	endtask
	task automatic rc(input logic e, input logic [9:0] a, input logic [7:0] exp);
		u_core.xfer(DMS_OP_READ, e, a, 8'h00, 3'h0, q);
		`CHK(q, exp)
	endtask
	task automatic do_reset;
		@(negedge clk_sys_in);
		nrst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		nrst_in = 1'b1;
	endtask
	task automatic complete_run;
		$display("Errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		num_errors = 0;
		samples_checked = 0;
		nrst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		nrst_in = 1'b1;
		foreach (ptr_offs[i]) rc(1'b0, {2'h0, ptr_offs[i]}, 8'h00);
		for (int s = 0; s < 3; s++) begin
			wr(1'b1, {s[1:0], 8'h80}, {6'h04, s[1:0]});
			wr(1'b1, {s[1:0], 8'hff}, {6'h08, s[1:0]});
		end
		for (int s = 0; s < 3; s++) begin
			rc(1'b1, {s[1:0], 8'h80}, {6'h04, s[1:0]});
			rc(1'b1, {s[1:0], 8'hff}, {6'h08, s[1:0]});
		end
		wr(1'b0, 10'h280, 8'h5a);
		`CHK(q, 8'h10)
		rc(1'b1, 10'h080, 8'h5a);
		rc(1'b1, 10'h280, 8'h12);
		u_core.xfer(DMS_OP_BIT_SET, 1'b1, 10'h180, 8'h00, 3'h7, q);
		`CHK(q, 8'h11)
		rc(1'b1, 10'h180, 8'h91);
		u_core.xfer(DMS_OP_BIT_CLR, 1'b1, 10'h180, 8'h00, 3'h0, q);
		rc(1'b1, 10'h180, 8'h90);
		wr(1'b0, 10'h047, 8'h5a);
		rc(1'b0, 10'h047, 8'h00);
		wr(1'b1, 10'h140, 8'h5a);
		rc(1'b1, 10'h140, 8'h00);
		u_core.xfer(DMS_OP_READ, 1'b1, 10'h17f, 8'h00, 3'h0, ro);
		`CHK(ro, 8'h00)
		wr(1'b1, 10'h17f, ~ro);
		rc(1'b1, 10'h17f, ro);
		wr(1'b1, 10'h114, 8'h33);
		wr(1'b1, 10'h014, 8'h44);
		wr(1'b1, 10'h010, 8'h66);
		rc(1'b1, 10'h114, 8'h33);
		rc(1'b1, 10'h214, 8'h44);
		rc(1'b1, 10'h110, 8'h66);
		wr(1'b0, 10'h001, 8'h80);
		wr(1'b0, 10'h000, 8'ha1);
		rc(1'b1, 10'h080, 8'ha1);
		rc(1'b1, 10'h180, 8'h90);
		wr(1'b0, 10'h001, 8'h02);
		rc(1'b0, 10'h000, 8'h00);
		wr(1'b0, 10'h004, 8'h01);
		wr(1'b0, 10'h003, 8'hff);
		wr(1'b0, 10'h002, 8'hb2);
		rc(1'b1, 10'h1ff, 8'hb2);
		u_core.xfer(DMS_OP_LOAD_ACC, 1'b0, 10'h003, 8'h00, 3'h0, q);
		`CHK(acc, 8'hff)
		// Increment of the low byte wraps to 00
		u_core.alu(8'h00);
		`CHK(acc, 8'h00)
		u_core.xfer(DMS_OP_STORE_ACC, 1'b0, 10'h003, 8'h00, 3'h0, q);
		rc(1'b0, 10'h003, 8'h00);
		rc(1'b0, 10'h004, 8'h01);
		rc(1'b0, 10'h002, 8'h00);
		wr(1'b0, 10'h00e, 8'h02);
		wr(1'b0, 10'h00d, 8'h90);
		wr(1'b0, 10'h00c, 8'hd4);
		rc(1'b1, 10'h290, 8'hd4);
		wr(1'b0, 10'h00e, 8'h03);
		rc(1'b0, 10'h00c, 8'h00);
		wr(1'b0, 10'h00c, 8'h77);
		wr(1'b0, 10'h00e, 8'h02);
		rc(1'b0, 10'h00c, 8'hd4);
		rc(1'b1, 10'h390, 8'h00);
		u_core.xfer(DMS_OP_LOAD_ACC, 1'b1, 10'h1ff, 8'h00, 3'h0, q);
		u_core.xfer(DMS_OP_STORE_ACC, 1'b1, 10'h2a0, 8'h00, 3'h0, q);
		rc(1'b1, 10'h2a0, 8'hb2);
		wr(1'b0, 10'h005, 8'h3c);
		`CHK(acc, 8'h3c)
		do_reset();
		`CHK(acc, 8'h00)
		rc(1'b0, 10'h001, 8'h00);
		complete_run();
	end

	// A hung handshake ends the run as a failure
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		num_errors++;
		complete_run();
	end
endmodule
